// *** sacc_regs.svh ***
// Purpose: register map and timing constants of the shared converter core configuration
// Assumes: plain register port, 16-bit registers at word indices
// Notes: constants only
// Summary of operation
// - format bit one gives fractional results
// - two-bit code picks 6/8/10/12-bit resolution
// - sample time is field plus two periods
// - zero gives two periods, one gives three
// - ready flag follows band gap and reference
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH
`define SACC_ADDR_W 4
`define SACC_OFS_FMT_RES 4'h0
`define SACC_OFS_REF_SAMP 4'h1
`define SACC_OFS_CTRL 4'h2
`define SACC_OFS_IRQ_STAT 4'h3
`define SACC_OFS_IRQ_MASK 4'h4
`define SACC_OUTPUT_FORMAT_SELECT_BIT 7
`define SACC_RES_HI 6
`define SACC_RES_LO 5
`define SACC_RDY_BIT 15
`define SACC_ERR_BIT 14
`define SACC_SAMP_HI 9
`define SACC_RES_RST 2'h3
`define SACC_SAMP_OFS 11'h002
`define SACC_IRQ_W 3
`endif

// *** sacc_pkg.sv ***
// Purpose: types of the shared converter core configuration
// Assumes: the constants header
// Notes: none
`include "sacc_regs.svh"
package sacc_pkg;
    typedef enum logic [1:0] {SACC_RES6, SACC_RES8, SACC_RES10, SACC_RES12} sacc_res_e;
    typedef struct packed {
        logic [`SACC_ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sacc_bus_s;
    typedef struct packed {
        logic fractional;
        sacc_res_e resolution;
        logic [3:0] result_bits;
        logic [10:0] sample_periods;
    } sacc_cfg_s;
    typedef struct packed {
        logic output_format_select;
        logic [1:0] res;
        logic [9:0] samp;
        logic enable;
        logic ready;
        logic ready_d;
        logic error;
        logic [`SACC_IRQ_W-1:0] stat;
        logic [`SACC_IRQ_W-1:0] mask;
        logic [15:0] rdata;
        logic irq;
        sacc_cfg_s cfg;
    } sacc_state_s;
endpackage : sacc_pkg

// *** sacc_core_cfg.sv ***
// Purpose: configuration registers and reference status of the shared converter core
// Assumes: inputs synchronous to ref_clk, synchronous active-high reset
// Notes: irq status bits are write-one-to-clear, set wins over clear
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "sacc_regs.svh"
module sacc_core_cfg (
    input wire logic ref_clk,
    input wire logic srst,
    input wire sacc_pkg::sacc_bus_s bus,
    output logic [15:0] rdata,
    input wire logic band_gap_ok,
    input wire logic reference_ok,
    output sacc_pkg::sacc_cfg_s cfg,
    output logic converter_enable,
    output logic irq
);
    import sacc_pkg::*;
    sacc_state_s s_reg;
    sacc_state_s s_next;
    logic ref_good;
    logic [`SACC_IRQ_W-1:0] ev;

    assign ref_good = band_gap_ok & reference_ok;

    always_comb begin
        s_next = s_reg;
        s_next.ready = ref_good;
        s_next.ready_d = s_reg.ready;
        ev = {s_reg.enable & ~ref_good & ~s_reg.error, s_reg.ready_d & ~s_reg.ready,
            s_reg.ready & ~s_reg.ready_d};
        s_next.rdata = 16'h0000;
        if (bus.wr) begin
            case (bus.addr)
                `SACC_OFS_FMT_RES: begin
                    s_next.output_format_select = bus.wdata[`SACC_OUTPUT_FORMAT_SELECT_BIT];
                    s_next.res = bus.wdata[`SACC_RES_HI:`SACC_RES_LO];
                end
                `SACC_OFS_REF_SAMP: begin
                    s_next.samp = bus.wdata[`SACC_SAMP_HI:0];
                end
                `SACC_OFS_CTRL: begin
                    s_next.enable = bus.wdata[0];
                    if (bus.wdata[1]) begin
                        s_next.error = 1'b0;
                    end
                end
                `SACC_OFS_IRQ_STAT: begin
                    s_next.stat = s_reg.stat & ~bus.wdata[`SACC_IRQ_W-1:0];
                end
                `SACC_OFS_IRQ_MASK: begin
                    s_next.mask = bus.wdata[`SACC_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // set after the write so it wins over a clear
        if (s_reg.enable && !ref_good) begin
            s_next.error = 1'b1;
        end
        s_next.stat = s_next.stat | ev;
        if (bus.rd) begin
            case (bus.addr)
                `SACC_OFS_FMT_RES: begin
                    s_next.rdata[`SACC_OUTPUT_FORMAT_SELECT_BIT] = s_reg.output_format_select;
                    s_next.rdata[`SACC_RES_HI:`SACC_RES_LO] = s_reg.res;
                end
                `SACC_OFS_REF_SAMP: begin
                    s_next.rdata[`SACC_RDY_BIT] = s_reg.ready;
                    s_next.rdata[`SACC_ERR_BIT] = s_reg.error;
                    s_next.rdata[`SACC_SAMP_HI:0] = s_reg.samp;
                end
                `SACC_OFS_CTRL: begin
                    s_next.rdata[0] = s_reg.enable;
                end
                `SACC_OFS_IRQ_STAT: begin
                    s_next.rdata[`SACC_IRQ_W-1:0] = s_reg.stat;
                end
                `SACC_OFS_IRQ_MASK: begin
                    s_next.rdata[`SACC_IRQ_W-1:0] = s_reg.mask;
                end
                default: begin
                end
            endcase
        end
        s_next.irq = |(s_next.stat & s_next.mask);
        s_next.cfg.fractional = s_next.output_format_select;
        s_next.cfg.resolution = sacc_res_e'(s_next.res);
        case (s_next.res)
            2'h3: s_next.cfg.result_bits = 4'hc;
            2'h2: s_next.cfg.result_bits = 4'ha;
            2'h1: s_next.cfg.result_bits = 4'h8;
            default: s_next.cfg.result_bits = 4'h6;
        endcase
        s_next.cfg.sample_periods = {1'b0, s_next.samp} + `SACC_SAMP_OFS;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.res <= `SACC_RES_RST;
            s_reg.cfg.resolution <= SACC_RES12;
            s_reg.cfg.result_bits <= 4'hc;
            s_reg.cfg.sample_periods <= `SACC_SAMP_OFS;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign cfg = s_reg.cfg;
    assign converter_enable = s_reg.enable;
    assign irq = s_reg.irq;

    chk_sample_time_map: assert property (@(posedge ref_clk) disable iff (srst)
        cfg.sample_periods == {1'b0, s_reg.samp} + 11'h002)
        else $error("sample periods not field plus two");
    chk_sample_zero_two: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.samp == 10'h000 |-> cfg.sample_periods == 11'h002)
        else $error("zero field not two periods");
    chk_format_follows: assert property (@(posedge ref_clk) disable iff (srst)
        bus.wr && bus.addr == `SACC_OFS_FMT_RES |=> cfg.fractional == $past(bus.wdata[7]))
        else $error("format not taken from write");
    chk_resolution_bits: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.res == 2'h1 |-> cfg.result_bits == 4'h8)
        else $error("code one not eight bits");
    chk_ready_follows: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 s_reg.ready == $past(ref_good))
        else $error("ready flag does not follow reference");
    chk_error_sets: assert property (@(posedge ref_clk) disable iff (srst)
        converter_enable && !ref_good |=> s_reg.error)
        else $error("error flag not set on loss");
    chk_error_holds: assert property (@(posedge ref_clk) disable iff (srst)
        !$past(converter_enable) && !$past(s_reg.error) |-> !s_reg.error)
        else $error("error flag set while disabled");
    chk_irq_level: assert property (@(posedge ref_clk) disable iff (srst)
        irq == |(s_reg.stat & s_reg.mask))
        else $error("irq does not match status and mask");
    chk_format_integer: assert property (@(posedge ref_clk) disable iff (srst)
        bus.wr && bus.addr == `SACC_OFS_FMT_RES && !bus.wdata[`SACC_OUTPUT_FORMAT_SELECT_BIT]
            |=> !cfg.fractional)
        else $error("integer format not taken from write");
    chk_format_holds: assert property (@(posedge ref_clk) disable iff (srst)
        !(bus.wr && bus.addr == `SACC_OFS_FMT_RES) |=> $stable(cfg.fractional))
        else $error("format changed without a write");
    chk_res_code_twelve: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.res == 2'h3 |-> cfg.result_bits == 4'hc)
        else $error("code three not twelve bits");
    chk_res_code_ten: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.res == 2'h2 |-> cfg.result_bits == 4'ha)
        else $error("code two not ten bits");
    chk_res_code_six: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.res == 2'h0 |-> cfg.result_bits == 4'h6)
        else $error("code zero not six bits");
    chk_res_enum_twelve: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.res == 2'h3 |-> cfg.resolution == SACC_RES12)
        else $error("code three not twelve bit mode");
    chk_res_enum_six: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.res == 2'h0 |-> cfg.resolution == SACC_RES6)
        else $error("code zero not six bit mode");
    chk_res_from_write: assert property (@(posedge ref_clk) disable iff (srst)
        bus.wr && bus.addr == `SACC_OFS_FMT_RES
            |=> s_reg.res == $past(bus.wdata[`SACC_RES_HI:`SACC_RES_LO]))
        else $error("resolution not taken from write");
    chk_sample_from_write: assert property (@(posedge ref_clk) disable iff (srst)
        bus.wr && bus.addr == `SACC_OFS_REF_SAMP
            |=> s_reg.samp == $past(bus.wdata[`SACC_SAMP_HI:0]))
        else $error("sample field not taken from write");
    chk_sample_one_three: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.samp == 10'h001 |-> cfg.sample_periods == 11'h003)
        else $error("field one not three periods");
    chk_sample_max_field: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.samp == 10'h3ff |-> cfg.sample_periods == 11'h401)
        else $error("full field not maximum periods");
    chk_sample_range: assert property (@(posedge ref_clk) disable iff (srst)
        cfg.sample_periods >= 11'h002 && cfg.sample_periods <= 11'h401)
        else $error("sample periods out of range");
    chk_ready_read: assert property (@(posedge ref_clk) disable iff (srst)
        bus.rd && bus.addr == `SACC_OFS_REF_SAMP
            |=> rdata[`SACC_RDY_BIT] == $past(s_reg.ready))
        else $error("ready flag read wrong");
    chk_ready_gap_lost: assert property (@(posedge ref_clk) disable iff (srst)
        !band_gap_ok |=> !s_reg.ready)
        else $error("ready flag high without band gap");
    chk_ready_ref_lost: assert property (@(posedge ref_clk) disable iff (srst)
        !reference_ok |=> !s_reg.ready)
        else $error("ready flag high without reference");
    chk_ready_both_ok: assert property (@(posedge ref_clk) disable iff (srst)
        band_gap_ok && reference_ok |=> s_reg.ready)
        else $error("ready flag low with reference good");
    chk_error_read: assert property (@(posedge ref_clk) disable iff (srst)
        bus.rd && bus.addr == `SACC_OFS_REF_SAMP
            |=> rdata[`SACC_ERR_BIT] == $past(s_reg.error))
        else $error("error flag read wrong");
    chk_error_sticky: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.error && !(bus.wr && bus.addr == `SACC_OFS_CTRL && bus.wdata[1])
            |=> s_reg.error)
        else $error("error flag dropped without clear");
    chk_error_clears: assert property (@(posedge ref_clk) disable iff (srst)
        !converter_enable && bus.wr && bus.addr == `SACC_OFS_CTRL && bus.wdata[1]
            |=> !s_reg.error)
        else $error("error flag not cleared");
    chk_enable_from_write: assert property (@(posedge ref_clk) disable iff (srst)
        bus.wr && bus.addr == `SACC_OFS_CTRL |=> converter_enable == $past(bus.wdata[0]))
        else $error("enable not taken from write");
    chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (srst)
        !bus.rd |=> rdata == 16'h0000)
        else $error("read data not zero without read");
    chk_rdata_unmapped: assert property (@(posedge ref_clk) disable iff (srst)
        bus.rd && bus.addr > `SACC_OFS_IRQ_MASK |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_format_read_zeros: assert property (@(posedge ref_clk) disable iff (srst)
        bus.rd && bus.addr == `SACC_OFS_FMT_RES
            |=> rdata[15:8] == 8'h00 && rdata[4:0] == 5'h00)
        else $error("unused format bits not zero");
    chk_sample_read_zeros: assert property (@(posedge ref_clk) disable iff (srst)
        bus.rd && bus.addr == `SACC_OFS_REF_SAMP |=> rdata[13:10] == 4'h0)
        else $error("unused sample bits not zero");
    chk_stat_rise_sets: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.ready && !s_reg.ready_d |=> s_reg.stat[0])
        else $error("ready rise not flagged");
    chk_stat_fall_sets: assert property (@(posedge ref_clk) disable iff (srst)
        !s_reg.ready && s_reg.ready_d |=> s_reg.stat[1])
        else $error("ready fall not flagged");
    chk_stat_error_sets: assert property (@(posedge ref_clk) disable iff (srst)
        converter_enable && !ref_good && !s_reg.error |=> s_reg.stat[2])
        else $error("error set not flagged");
    chk_stat_clear_one: assert property (@(posedge ref_clk) disable iff (srst)
        bus.wr && bus.addr == `SACC_OFS_IRQ_STAT && bus.wdata[0]
            && !(s_reg.ready && !s_reg.ready_d) |=> !s_reg.stat[0])
        else $error("status bit not cleared by one");
    chk_mask_from_write: assert property (@(posedge ref_clk) disable iff (srst)
        bus.wr && bus.addr == `SACC_OFS_IRQ_MASK |=> s_reg.mask == $past(bus.wdata[2:0]))
        else $error("mask not taken from write");
    chk_irq_masked_off: assert property (@(posedge ref_clk) disable iff (srst)
        s_reg.mask == 3'h0 |-> !irq)
        else $error("irq high with all masked");
endmodule : sacc_core_cfg

// *** sacc_ref_model.sv ***
// Purpose: band gap and reference model beside the converter core
// Assumes: one clock, sync reset
// Notes: warms up 15 cycles after reset; lose_ref drops the reference
`timescale 1ns/10ps
module sacc_ref_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic lose_ref,
    output logic band_gap_ok,
    output logic reference_ok
);
    logic [3:0] warm_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) warm_reg <= 4'h0;
        else if (warm_reg != 4'hf) warm_reg <= warm_reg + 4'h1;
    end
    assign band_gap_ok = (warm_reg == 4'hf);
    assign reference_ok = band_gap_ok & !lose_ref;
endmodule : sacc_ref_model

// *** shared_adc_core_config_test.sv ***
// Purpose: register level test of the converter core configuration
// Assumes: one cycle strobes, read data the cycle after
// Notes: irq mask at index 4, status at 3, control at 2
`timescale 1ns/10ps
module shared_adc_core_config_test;
    import sacc_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic lose_ref = 1'b0;
    sacc_bus_s bus = '0;
    logic [15:0] rdata;
    logic band_gap_ok, reference_ok, converter_enable, irq;
    sacc_cfg_s cfg;
    int err_count = 0;
    int n_compared = 0;
    logic [9:0] sv[3] = '{10'h000, 10'h001, 10'h3ff};
    sacc_core_cfg dut (.ref_clk(ref_clk), .srst(srst), .bus(bus), .rdata(rdata),
        .band_gap_ok(band_gap_ok), .reference_ok(reference_ok), .cfg(cfg),
        .converter_enable(converter_enable), .irq(irq));
    sacc_ref_model ref_side (.ref_clk(ref_clk), .srst(srst), .lose_ref(lose_ref),
        .band_gap_ok(band_gap_ok), .reference_ok(reference_ok));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic final_report;
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        rd(4'h0, 16'h0060);
        chk(cfg, {1'b0, 2'h3, 4'hc, 11'h002});
        rd(4'h1, 16'h0000);
        repeat (20) @(posedge ref_clk);
        rd(4'h1, 16'h8000);
        rd(4'h3, 16'h0001);
        wr(4'h4, 16'h0007);
        chk(irq, 1'b1);
        wr(4'h3, 16'h0007);
        chk(irq, 1'b0);
        for (int c = 0; c < 4; c++) begin
            wr(4'h0, {8'h00, c[0], 2'(c), 5'h00});
            chk(cfg, {c[0], 2'(c), 4'(6 + 2 * c), 11'h002});
            rd(4'h0, {8'h00, c[0], 2'(c), 5'h00});
        end
        foreach (sv[i]) begin
            wr(4'h1, {6'h00, sv[i]});
            chk(cfg.sample_periods, {1'b0, sv[i]} + 11'h002);
            rd(4'h1, {6'h20, sv[i]});
        end
        wr(4'h1, 16'hc000);
        rd(4'h1, 16'h8000);
        wr(4'h2, 16'h0001);
        chk(converter_enable, 1'b1);
        @(posedge ref_clk);
        lose_ref <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(4'h1, 16'h4000);
        rd(4'h3, 16'h0006);
        chk(irq, 1'b1);
        wr(4'h2, 16'h0002);
        rd(4'h1, 16'h4000);
        chk(converter_enable, 1'b0);
        wr(4'h2, 16'h0002);
        rd(4'h1, 16'h0000);
        @(posedge ref_clk);
        lose_ref <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr(4'h2, 16'h0003);
        rd(4'h1, 16'h8000);
        rd(4'h5, 16'h0000);
        final_report();
    end
endmodule : shared_adc_core_config_test
